/* File: rtl/cssd_dev.sv */
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module cssd_dev
	import cssd_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Link towards arbiter, memory and consumers
	cssd_if.dev       lnk,
	// Sound status for the system
	output var  logic snd_irq_out,
	output var  logic [2:0] snd_status
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                       vid_en;
		logic [PTR_W-1:0]           curs_init;
		logic [PTR_W-1:0]           curs_cur;
		logic                       snd_en;
		logic                       snd_mask;
		logic [1:0][PTR_W-1:0]      scur;
		logic [1:0][PAGE_QW_W-1:0]  send;
		logic [1:0]                 slast;
		logic [1:0]                 sstop;
		logic [1:0]                 sval;
		logic                       ovr;
		logic                       intr;
		logic                       ab;
		logic                       busy;
		logic                       chan;
		logic [1:0]                 word;
		logic                       mem_rd;
		logic [ADDR_W-1:0]          mem_addr;
		logic                       out_valid;
		logic                       out_chan;
		logic [31:0]                out_data;
		logic                       cursor_done;
		logic                       sound_done;
		logic                       irq;
		logic                       two_lines;
	} cssd_dev_st_t;

	cssd_dev_st_t q;
	cssd_dev_st_t d;
	logic         wp;
	logic         snd_run;
	logic         p;
	logic [PAGE_QW_W-1:0] nxt_low;

	// Pair addressed by a pointer write
	assign wp = (lnk.prog_addr == REG_SCUR_B) ||
	            (lnk.prog_addr == REG_SEND_B);
	// Channel live only when enabled and current pair programmed
	assign snd_run = q.snd_en && !q.ovr && q.sval[q.ab];
	assign p       = q.ab;
	assign nxt_low = q.scur[p][PAGE_QW_W-1:0] + 8'h01;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d             = q;
		d.out_valid   = 1'b0;
		d.cursor_done = 1'b0;
		d.sound_done  = 1'b0;

		// Register writes
		if (lnk.prog_wr) begin
			case (lnk.prog_addr)
				REG_VCTL: begin
					d.vid_en = lnk.prog_wdata[VCTL_EN_BIT];
				end
				REG_CINIT: begin
					d.curs_init = lnk.prog_wdata[ADDR_W-1:QW_SHIFT];
					d.curs_cur  = lnk.prog_wdata[ADDR_W-1:QW_SHIFT];
				end
				REG_SCTL: begin
					d.snd_en   = lnk.prog_wdata[SCTL_EN_BIT];
					d.snd_mask = lnk.prog_wdata[SCTL_MASK_BIT];
				end
				REG_SCUR_A, REG_SCUR_B: begin
					d.scur[wp] = lnk.prog_wdata[ADDR_W-1:QW_SHIFT];
				end
				REG_SEND_A, REG_SEND_B: begin
					d.send[wp]  = lnk.prog_wdata[11:QW_SHIFT];
					d.slast[wp] = lnk.prog_wdata[SEND_LAST_BIT];
					d.sstop[wp] = lnk.prog_wdata[SEND_STOP_BIT];
					d.sval[wp]  = 1'b1;
					// Only end writes move the state
					if (q.ovr || !q.sval[q.ab]) begin
						d.ab   = wp;
						d.ovr  = 1'b0;
						d.intr = 1'b0;
					end else if (wp != q.ab) begin
						d.intr = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Cursor restarts each frame
		if (lnk.flyback) begin
			d.curs_cur = q.curs_init;
		end

		// Fetch engine, idle one cycle after done so a request can drop
		if (!q.busy && !q.cursor_done && !q.sound_done) begin
			if (q.vid_en && lnk.cursor_req && !lnk.video_req) begin
				d.busy     = 1'b1;
				d.mem_rd   = 1'b1;
				d.chan     = 1'b0;
				d.word     = 2'h0;
				d.mem_addr = {q.curs_cur, 4'h0};
			end else if (snd_run && lnk.sound_req && !lnk.video_req &&
			             !lnk.cursor_req) begin
				d.busy     = 1'b1;
				d.mem_rd   = 1'b1;
				d.chan     = 1'b1;
				d.word     = 2'h0;
				d.mem_addr = {q.scur[p], 4'h0};
			end
		end else if (q.busy && lnk.mem_ack) begin
			d.out_valid = 1'b1;
			d.out_chan  = q.chan;
			d.out_data  = lnk.mem_data;
			d.word      = q.word + 2'h1;
			d.mem_addr  = q.mem_addr + WORD_BYTES;
			if (q.word == LAST_WORD) begin
				d.busy   = 1'b0;
				d.mem_rd = 1'b0;
				if (!q.chan) begin
					// No end check on cursor
					d.curs_cur    = q.curs_cur + 24'h000001;
					d.cursor_done = 1'b1;
				end else begin
					d.sound_done = 1'b1;
					if (q.slast[p]) begin
						d.sval[p] = 1'b0;
						d.intr    = 1'b1;
						if (q.sstop[p]) begin
							d.sval = 2'h0;
						end else if (q.sval[~p]) begin
							d.ab = ~p;
						end else begin
							d.ovr = 1'b1;
						end
					end else begin
						d.scur[p] = {q.scur[p][PTR_W-1:PAGE_QW_W], nxt_low};
						if (nxt_low == q.send[p]) begin
							d.slast[p] = 1'b1;
						end
					end
				end
			end
		end

		d.irq       = d.intr && d.snd_mask;
		d.two_lines = !lnk.hires;
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q      <= '0;
			q.ovr  <= SND_RESET_STATE[2];
			q.intr <= SND_RESET_STATE[1];
			q.ab   <= SND_RESET_STATE[0];
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign lnk.mem_rd      = q.mem_rd;
	assign lnk.mem_addr    = q.mem_addr;
	assign lnk.out_valid   = q.out_valid;
	assign lnk.out_chan    = q.out_chan;
	assign lnk.out_data    = q.out_data;
	assign lnk.cursor_done = q.cursor_done;
	assign lnk.sound_done  = q.sound_done;
	assign lnk.snd_state   = {q.ovr, q.intr, q.ab};
	assign lnk.snd_irq     = q.irq;
	assign lnk.two_lines   = q.two_lines;
	assign snd_irq_out     = q.irq;
	assign snd_status      = {q.ovr, q.intr, q.ab};

endmodule : cssd_dev
`default_nettype wire

/* File: rtl/cssd_host.sv */
`timescale 1ns/10ps
`default_nettype none
module cssd_host
	import cssd_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Link towards the channels
	cssd_if.host             lnk
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0]  dev_addr;
		logic [31:0] dev_data;
		logic        prog_wr;
		logic        creq;
		logic        sreq;
		logic        vreq;
		logic        hires;
		logic        flyback;
		logic        mem_ack;
		logic [31:0] mem_data;
		logic [31:0] last_data;
		logic [27:0] last_addr;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} cssd_host_st_t;

	cssd_host_st_t q;
	cssd_host_st_t d;
	logic          wr;
	logic          mapped;

	assign wr     = psel && penable && q.pready && pwrite;
	assign mapped = (paddr == HREG_CMD) || (paddr == HREG_DATA) ||
	                (paddr == HREG_REQ) || (paddr == HREG_STAT) ||
	                (paddr == HREG_LDATA) || (paddr == HREG_LADDR);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d         = q;
		d.prog_wr = 1'b0;
		d.flyback = 1'b0;
		d.pready  = psel && !penable;
		// Memory answers each word one cycle after the request
		d.mem_ack  = lnk.mem_rd && !q.mem_ack;
		d.mem_data = {4'h0, lnk.mem_addr};
		if (lnk.mem_rd) begin
			d.last_addr = lnk.mem_addr;
		end
		if (lnk.out_valid) begin
			d.last_data = lnk.out_data;
		end
		// Requests drop when their fetch completes
		if (lnk.cursor_done) begin
			d.creq = 1'b0;
		end
		if (lnk.sound_done) begin
			d.sreq = 1'b0;
		end
		if (psel && !penable) begin
			d.pslverr = !mapped;
			case (paddr)
				HREG_CMD:   d.prdata = {28'h0000000, q.dev_addr};
				HREG_DATA:  d.prdata = q.dev_data;
				HREG_REQ:   d.prdata = {27'h0000000, q.flyback, q.hires,
				                        q.vreq, q.sreq, q.creq};
				HREG_STAT:  d.prdata = {27'h0000000, lnk.two_lines,
				                        lnk.snd_irq, lnk.snd_state};
				HREG_LDATA: d.prdata = q.last_data;
				HREG_LADDR: d.prdata = {4'h0, q.last_addr};
				default:    d.prdata = 32'h00000000;
			endcase
		end
		// Software write wins over a completion in the same cycle
		if (wr) begin
			case (paddr)
				HREG_CMD: begin
					d.dev_addr = pwdata[3:0];
					d.prog_wr  = 1'b1;
				end
				HREG_DATA: d.dev_data = pwdata;
				HREG_REQ: begin
					d.creq    = pwdata[REQ_CURS_BIT];
					d.sreq    = pwdata[REQ_SND_BIT];
					d.vreq    = pwdata[REQ_VID_BIT];
					d.hires   = pwdata[REQ_HIRES_BIT];
					d.flyback = pwdata[REQ_FLYB_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata         = q.prdata;
	assign pready         = q.pready;
	assign pslverr        = q.pslverr;
	assign lnk.prog_wr    = q.prog_wr;
	assign lnk.prog_addr  = q.dev_addr;
	assign lnk.prog_wdata = q.dev_data;
	assign lnk.flyback    = q.flyback;
	assign lnk.hires      = q.hires;
	assign lnk.video_req  = q.vreq;
	assign lnk.cursor_req = q.creq;
	assign lnk.sound_req  = q.sreq;
	assign lnk.mem_ack    = q.mem_ack;
	assign lnk.mem_data   = q.mem_data;

endmodule : cssd_host
`default_nettype wire

/* File: rtl/cssd_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface cssd_if;
	logic        prog_wr;
	logic [3:0]  prog_addr;
	logic [31:0] prog_wdata;
	logic        flyback;
	logic        hires;
	logic        video_req;
	logic        cursor_req;
	logic        sound_req;
	logic        mem_ack;
	logic [31:0] mem_data;
	logic        mem_rd;
	logic [27:0] mem_addr;
	logic        out_valid;
	logic        out_chan;
	logic [31:0] out_data;
	logic        cursor_done;
	logic        sound_done;
	logic [2:0]  snd_state;
	logic        snd_irq;
	logic        two_lines;

	modport dev (
		input  prog_wr, prog_addr, prog_wdata, flyback, hires, video_req,
		input  cursor_req, sound_req, mem_ack, mem_data,
		output mem_rd, mem_addr, out_valid, out_chan, out_data,
		output cursor_done, sound_done, snd_state, snd_irq, two_lines
	);
	modport host (
		output prog_wr, prog_addr, prog_wdata, flyback, hires, video_req,
		output cursor_req, sound_req, mem_ack, mem_data,
		input  mem_rd, mem_addr, out_valid, out_chan, out_data,
		input  cursor_done, sound_done, snd_state, snd_irq, two_lines
	);
endinterface : cssd_if
`default_nettype wire

/* File: rtl/cssd_pkg.sv */
package cssd_pkg;

	// ------------------------------------------------------------------
	// Device register indices
	// ------------------------------------------------------------------
	localparam logic [3:0] REG_VCTL   = 4'h0;
	localparam logic [3:0] REG_CINIT  = 4'h1;
	localparam logic [3:0] REG_SCTL   = 4'h2;
	localparam logic [3:0] REG_SCUR_A = 4'h3;
	localparam logic [3:0] REG_SEND_A = 4'h4;
	localparam logic [3:0] REG_SCUR_B = 4'h5;
	localparam logic [3:0] REG_SEND_B = 4'h6;

	// ------------------------------------------------------------------
	// Device field positions
	// ------------------------------------------------------------------
	localparam int VCTL_EN_BIT   = 5;
	localparam int SCTL_EN_BIT   = 0;
	localparam int SCTL_MASK_BIT = 1;
	localparam int SEND_LAST_BIT = 30;
	localparam int SEND_STOP_BIT = 31;
	localparam int ADDR_W        = 28;
	localparam int QW_SHIFT      = 4;
	localparam int PTR_W         = ADDR_W - QW_SHIFT;
	localparam int PAGE_QW_W     = 12 - QW_SHIFT;

	// ------------------------------------------------------------------
	// Transfer and reset constants
	// ------------------------------------------------------------------
	localparam logic [1:0]        LAST_WORD       = 2'h3;
	localparam logic [ADDR_W-1:0] WORD_BYTES      = 28'h0000004;
	localparam logic [2:0]        SND_RESET_STATE = 3'h6;

	// ------------------------------------------------------------------
	// Host APB register offsets and fields
	// ------------------------------------------------------------------
	localparam logic [7:0] HREG_CMD   = 8'h00;
	localparam logic [7:0] HREG_DATA  = 8'h04;
	localparam logic [7:0] HREG_REQ   = 8'h08;
	localparam logic [7:0] HREG_STAT  = 8'h0c;
	localparam logic [7:0] HREG_LDATA = 8'h10;
	localparam logic [7:0] HREG_LADDR = 8'h14;
	localparam int REQ_CURS_BIT  = 0;
	localparam int REQ_SND_BIT   = 1;
	localparam int REQ_VID_BIT   = 2;
	localparam int REQ_HIRES_BIT = 3;
	localparam int REQ_FLYB_BIT  = 4;

endpackage : cssd_pkg

/* File: sim/cssd_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module cssd_chk (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Link signals
	input wire logic        mem_rd,
	input wire logic [27:0] mem_addr,
	input wire logic        out_valid,
	input wire logic        cursor_done,
	input wire logic        sound_done,
	input wire logic [2:0]  snd_state,
	input wire logic        snd_irq,
	input wire logic        two_lines,
	input wire logic        video_req,
	input wire logic        hires
);
	// ------------------------------------------------------------------
	// Words delivered in the current quad word
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] vcnt;
	} cssd_chk_st_t;

	cssd_chk_st_t st_q;
	cssd_chk_st_t st_d;

	always_comb begin
		st_d = st_q;
		if (cursor_done || sound_done)
			st_d.vcnt = 2'h0;
		else if (out_valid)
			st_d.vcnt = st_q.vcnt + 2'h1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_RESET_STATE: assert property ($rose(presetn) |-> snd_state == 3'h6)
		else $error("sound state not 110 after reset");
	AST_FOUR_WORDS: assert property ((cursor_done || sound_done) |->
		out_valid && st_q.vcnt == 2'h3)
		else $error("quad word not four words");
	AST_ADDR_STEP: assert property ((out_valid && !(cursor_done || sound_done))
		|-> mem_addr == $past(mem_addr) + 28'h0000004)
		else $error("word address did not step by four");
	AST_VIDEO_BLOCKS: assert property ($rose(mem_rd) |-> !$past(video_req))
		else $error("fetch started under video request");
	AST_IRQ_CAUSE: assert property (snd_irq |-> snd_state[1])
		else $error("sound interrupt without interrupt bit");
	AST_TWO_LINES: assert property ($past(presetn) |-> two_lines == !$past(hires))
		else $error("two line flag wrong");
	AST_OVR_HAS_INT: assert property (snd_state[2] |-> snd_state[1])
		else $error("overrun without interrupt bit");
	AST_DONE_PULSE: assert property ((cursor_done || sound_done) |=>
		!(cursor_done || sound_done))
		else $error("done pulse longer than one cycle");
endmodule : cssd_chk
`default_nettype wire

/* File: sim/cursor_sound_dma_channels_test.sv */
`timescale 1ns/10ps
`default_nettype none
module cursor_sound_dma_channels_test
	import cssd_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic        pready, pslverr, rd_err, snd_irq_out;
	logic [2:0]  snd_status;
	int          fail_count, samples_checked;

	cssd_if cssd_if_i ();
	cssd_dev cssd_dev_i (.pclk(pclk), .presetn(presetn), .lnk(cssd_if_i.dev),
		.snd_irq_out(snd_irq_out), .snd_status(snd_status));
	cssd_host cssd_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lnk(cssd_if_i.host));
	cssd_chk cssd_chk_i (.pclk(pclk), .presetn(presetn),
		.mem_rd(cssd_if_i.mem_rd), .mem_addr(cssd_if_i.mem_addr),
		.out_valid(cssd_if_i.out_valid), .cursor_done(cssd_if_i.cursor_done),
		.sound_done(cssd_if_i.sound_done), .snd_state(cssd_if_i.snd_state),
		.snd_irq(cssd_if_i.snd_irq), .two_lines(cssd_if_i.two_lines),
		.video_req(cssd_if_i.video_req), .hires(cssd_if_i.hires));

	always #25 pclk = ~pclk;

	// ------------------------------------------------------------------
	// Bus and checking tasks
	// ------------------------------------------------------------------
	task automatic summarize;
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fail_count++;
			summarize();
		end
		rd_data = prdata;
		rd_err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_data & m, e);
	endtask : rd_chk

	task automatic dev_wr(input logic [3:0] idx, input logic [31:0] d);
		apb(1'b1, HREG_DATA, d);
		apb(1'b1, HREG_CMD, {28'h0, idx});
	endtask : dev_wr

	// Poll a request bit until the fetch clears it
	task automatic wait_clr(input int b);
		int i;
		for (i = 0; i < 100; i++) begin
			apb(1'b0, HREG_REQ, 32'h0);
			if (rd_data[b] === 1'b0)
				break;
		end
		if (i == 100) begin
			fail_count++;
			summarize();
		end
	endtask : wait_clr

	task automatic fetch(input logic [31:0] req, input int b,
		input logic [31:0] last);
		apb(1'b1, HREG_REQ, req);
		wait_clr(b);
		rd_chk(HREG_LADDR, 32'hfffffff, last);
	endtask : fetch

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		rd_chk(HREG_STAT, 32'h1f, 32'h16);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, rd_err}, 32'h1);
		chk(rd_data, 32'h0);
		apb(1'b1, HREG_REQ, 32'h8);
		repeat (3) @(posedge pclk);
		rd_chk(HREG_STAT, 32'h10, 32'h0);
	endtask : t_reset

	task automatic t_cursor;
		dev_wr(REG_CINIT, 32'h0010000);
		apb(1'b1, HREG_REQ, 32'h1);
		repeat (20) @(posedge pclk);
		rd_chk(HREG_LADDR, 32'hfffffff, 32'h0);
		dev_wr(REG_VCTL, 32'h20);
		wait_clr(REQ_CURS_BIT);
		rd_chk(HREG_LADDR, 32'hfffffff, 32'h001000c);
		rd_chk(HREG_LDATA, 32'hffffffff, 32'h001000c);
		fetch(32'h1, REQ_CURS_BIT, 32'h001001c);
		apb(1'b1, HREG_REQ, 32'h10);
		fetch(32'h1, REQ_CURS_BIT, 32'h001000c);
		dev_wr(REG_VCTL, 32'h0);
	endtask : t_cursor

	task automatic t_sound;
		dev_wr(REG_SCTL, 32'h3);
		dev_wr(REG_SCUR_A, 32'h0002ff0);
		dev_wr(REG_SEND_A, 32'h0002000);
		rd_chk(HREG_STAT, 32'h7, 32'h0);
		fetch(32'h2, REQ_SND_BIT, 32'h0002ffc);
		dev_wr(REG_SCUR_B, 32'h000400f);
		dev_wr(REG_SEND_B, 32'h40004000);
		fetch(32'h2, REQ_SND_BIT, 32'h000200c);
		rd_chk(HREG_STAT, 32'hf, 32'hb);
		chk({29'h0, snd_status}, 32'h3);
		chk({31'h0, snd_irq_out}, 32'h1);
		fetch(32'h2, REQ_SND_BIT, 32'h000400c);
		rd_chk(HREG_STAT, 32'he, 32'he);
		dev_wr(REG_SCTL, 32'h0);
		dev_wr(REG_SCUR_A, 32'h0002000);
		dev_wr(REG_SEND_A, 32'h40002000);
		apb(1'b1, HREG_REQ, 32'h2);
		repeat (20) @(posedge pclk);
		rd_chk(HREG_STAT, 32'hf, 32'h0);
		rd_chk(HREG_LADDR, 32'hfffffff, 32'h000400c);
		apb(1'b1, HREG_REQ, 32'h6);
		dev_wr(REG_SCTL, 32'h1);
		repeat (20) @(posedge pclk);
		rd_chk(HREG_REQ, 32'h7, 32'h6);
		rd_chk(HREG_LADDR, 32'hfffffff, 32'h000400c);
		fetch(32'h2, REQ_SND_BIT, 32'h000200c);
		rd_chk(HREG_STAT, 32'h6, 32'h6);
	endtask : t_sound

	initial begin
		pclk            = 1'b0;
		presetn         = 1'b0;
		psel            = 1'b0;
		penable         = 1'b0;
		pwrite          = 1'b0;
		paddr           = 8'h00;
		pwdata          = 32'h0;
		fail_count      = 0;
		samples_checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_cursor();
		t_sound();
		summarize();
	end
endmodule : cursor_sound_dma_channels_test
`default_nettype wire
